// ---- urff_dev.sv ----
// Contract
// RL1 - Firmware samples index flags around reads, completes
// RL2 - Control endpoints preferably single-packet receive mode
// RL3 - Reserved bit 5 reads zero, written zero
// RL4 - Flush flag only with feature enable, SOF-updated
// RL5 - Index advances on data set; iso at SOF
// RL6 - Unfinished iso set flushed at next SOF
// RL7 - Data port reads ignored while flush set
// RL8 - Firmware discards iso data if flush set
// RL9 - Firmware never late on consecutive frames
// RL10 - Firmware always sets read-complete after set read
// RL11 - Read-complete write clears the flush flag
// RL12 - Empty flag set when current set empty
// RL13 - Empty flag live, never SOF deferred
// RL14 - Single-cycle SOF pulse drives iso updates
`timescale 1ns/10ps
`include "urff_consts.svh"

module urff_dev
    import urff_pkg::*;
#(
    parameter int DEPTH = `URFF_SET_DEPTH
)
(
    input  wire logic       MCLK,
    input  wire logic       NRST,
    urff_if.dev             BUS,
    input  wire logic       FEATURE_ENABLE,
    input  wire logic       ISO_MODE,
    input  wire logic       SOF_PULSE,
    input  wire logic       USB_VALID,
    input  wire urff_byte_t USB_DATA,
    input  wire logic       USB_LAST,
    output logic            USB_READY,
    output logic            FLUSH_EVENT
);

    localparam int CW = $clog2(DEPTH + 1);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    // ============================================================
    // State
    urff_byte_t        mem_q  [2][DEPTH];
    urff_byte_t        mem_d  [2][DEPTH];
    logic [CW-1:0]     len_q  [2];
    logic [CW-1:0]     len_d  [2];
    logic              wslot_q, wslot_d;
    logic [CW-1:0]     wptr_q,  wptr_d;
    logic              rslot_q, rslot_d;
    logic [CW-1:0]     rptr_q,  rptr_d;
    logic [1:0]        vis_q,   vis_d;
    logic [1:0]        pend_q,  pend_d;
    logic              armed_q, armed_d;
    logic              flush_q, flush_d;
    logic              rdy_q,   rdy_d;
    logic              fev_q,   fev_d;
    urff_flag_t        flag_q,  flag_d;
    urff_byte_t        rdat_q,  rdat_d;
    logic              emp_d;

    function automatic logic [AW-1:0] idx(input logic [CW-1:0] p);
        idx = p[AW-1:0];
    endfunction

    function automatic logic [CW-1:0] inc(input logic [CW-1:0] p);
        inc = CW'(p + 1'b1);
    endfunction

    // ============================================================
    // Next state
    always_comb
    begin
        mem_d   = mem_q;
        len_d   = len_q;
        wslot_d = wslot_q;
        wptr_d  = wptr_q;
        rslot_d = rslot_q;
        rptr_d  = rptr_q;
        vis_d   = vis_q;
        pend_d  = pend_q;
        armed_d = armed_q;
        flush_d = flush_q;
        fev_d   = 1'b0;

        // Host side fills the write slot
        if (USB_VALID && rdy_q)
        begin
            mem_d[wslot_q][idx(wptr_q)] = USB_DATA;
            wptr_d = inc(wptr_q);
            if (USB_LAST)
            begin
                len_d[wslot_q] = inc(wptr_q);
                wptr_d         = '0;
                wslot_d        = ~wslot_q;
                if (ISO_MODE)
                begin
                    pend_d = 2'(pend_d + 1'b1);                       // RL5
                end
                else
                begin
                    vis_d = 2'(vis_d + 1'b1);                         // RL5
                end
            end
        end

        // Reads are blocked after a flush so the new set stays intact
        if (BUS.rd_strobe && !flush_q && vis_q != 2'h0 && rptr_q < len_q[rslot_q])
        begin
            rptr_d = inc(rptr_q);                                     // RL7
        end

        // Read complete
        if (BUS.rc_strobe)
        begin
            flush_d = 1'b0;                                           // RL11
            if (!flush_q && vis_d != 2'h0)
            begin
                vis_d   = 2'(vis_d - 1'b1);
                rslot_d = ~rslot_q;
                rptr_d  = '0;
            end
            armed_d = ISO_MODE && FEATURE_ENABLE && vis_d != 2'h0;
        end

        // Frame boundary: flush check first, then reveal deferred sets
        if (SOF_PULSE && ISO_MODE)                                    // RL14
        begin
            if (FEATURE_ENABLE && armed_d && vis_d != 2'h0)           // RL4
            begin
                vis_d   = 2'(vis_d - 1'b1);                           // RL6
                rslot_d = ~rslot_d;
                rptr_d  = '0;
                flush_d = 1'b1;                                       // RL6
                fev_d   = 1'b1;
            end
            vis_d   = 2'(vis_d + pend_d);                             // RL5
            pend_d  = 2'h0;
            armed_d = FEATURE_ENABLE && vis_d != 2'h0;
        end

        if (!ISO_MODE)
        begin
            armed_d = 1'b0;
        end

        rdy_d = (2'(vis_d + pend_d) < `URFF_SETS_MAX) && (wptr_d < CW'(DEPTH));

        // Tracks live contents, not the frame
        emp_d = (vis_d == 2'h0) || (rptr_d >= len_d[rslot_d]);        // RL12 RL13

        flag_d                    = 8'h00;
        flag_d[`URFF_FLAG_FIF_HI] = (vis_d == `URFF_SETS_MAX);
        flag_d[`URFF_FLAG_FIF_LO] = (vis_d != 2'h0);
        flag_d[`URFF_FLAG_RSVD]   = 1'b0;                             // RL3
        flag_d[`URFF_FLAG_FLUSH]  = flush_d && FEATURE_ENABLE;        // RL4
        flag_d[`URFF_FLAG_EMPTY]  = emp_d;                            // RL12

        rdat_d = mem_d[rslot_d][idx(rptr_d)];
    end

    // ============================================================
    // Registers
    always_ff @(posedge MCLK)
    begin
        if (!NRST)
        begin
            for (int s = 0; s < 2; s++)
            begin
                len_q[s] <= '0;
                for (int i = 0; i < DEPTH; i++)
                begin
                    mem_q[s][i] <= '0;
                end
            end
            wslot_q <= 1'b0;
            wptr_q  <= '0;
            rslot_q <= 1'b0;
            rptr_q  <= '0;
            vis_q   <= 2'h0;
            pend_q  <= 2'h0;
            armed_q <= 1'b0;
            flush_q <= 1'b0;
            rdy_q   <= 1'b0;
            fev_q   <= 1'b0;
            flag_q  <= `URFF_FLAG_RESET;
            rdat_q  <= '0;
        end
        else
        begin
            mem_q   <= mem_d;
            len_q   <= len_d;
            wslot_q <= wslot_d;
            wptr_q  <= wptr_d;
            rslot_q <= rslot_d;
            rptr_q  <= rptr_d;
            vis_q   <= vis_d;
            pend_q  <= pend_d;
            armed_q <= armed_d;
            flush_q <= flush_d;
            rdy_q   <= rdy_d;
            fev_q   <= fev_d;
            flag_q  <= flag_d;
            rdat_q  <= rdat_d;
        end
    end

    // ============================================================
    // Outputs
    assign USB_READY   = rdy_q;
    assign FLUSH_EVENT = fev_q;
    assign BUS.flag    = flag_q;
    assign BUS.rd_data = rdat_q;

endmodule // urff_dev

// ---- urff_consts.svh ----
`ifndef URFF_CONSTS_SVH
`define URFF_CONSTS_SVH

// ============================================================
// Receive flag register layout
`define URFF_FLAG_FIF_HI     7
`define URFF_FLAG_FIF_LO     6
`define URFF_FLAG_RSVD       5
`define URFF_FLAG_FLUSH      4
`define URFF_FLAG_EMPTY      3
`define URFF_FLAG_RESET      8'h08

// ============================================================
// Storage shape
`define URFF_SET_DEPTH       64
`define URFF_SETS_MAX        2'h2
`define URFF_DATA_W          8

`endif

// ---- urff_pkg.sv ----
`include "urff_consts.svh"

package urff_pkg;

    typedef logic [`URFF_DATA_W-1:0] urff_byte_t;
    typedef logic [7:0]              urff_flag_t;

    // Firmware end sequencer
    typedef enum logic [0:0]
    {
        URFF_IDLE = 1'b0,
        URFF_WAIT = 1'b1
    } urff_state_e;

    // Firmware end commands
    typedef enum logic [0:0]
    {
        URFF_OP_READ = 1'b0,
        URFF_OP_DONE = 1'b1
    } urff_op_e;

endpackage

// ---- urff_if.sv ----
`timescale 1ns/10ps
`include "urff_consts.svh"

interface urff_if;
    import urff_pkg::*;

    logic       rd_strobe;
    logic       rc_strobe;
    urff_byte_t rd_data;
    urff_flag_t flag;

    modport dev
    (
        input  rd_strobe,
        input  rc_strobe,
        output rd_data,
        output flag
    );

    modport fw
    (
        output rd_strobe,
        output rc_strobe,
        input  rd_data,
        input  flag
    );
endinterface

// ---- urff_fw.sv ----
`timescale 1ns/10ps
`include "urff_consts.svh"

module urff_fw
    import urff_pkg::*;
(
    input  wire logic       MCLK,
    input  wire logic       NRST,
    urff_if.fw              BUS,
    input  wire logic       CMD_VALID,
    input  wire urff_op_e   CMD_OP,
    output logic            CMD_READY,
    output logic            OUT_VALID,
    output urff_byte_t      OUT_DATA,
    input  wire logic       OUT_READY,
    output urff_flag_t      FLAG_PRE,
    output urff_flag_t      FLAG_POST,
    output logic            DONE,
    output logic            DISCARD
);

    // ============================================================
    // State
    urff_state_e st_q,   st_d;
    urff_op_e    op_q,   op_d;
    logic        rd_q,   rd_d;
    logic        rc_q,   rc_d;
    logic        rdy_q,  rdy_d;
    logic        done_q, done_d;
    logic        disc_q, disc_d;
    urff_flag_t  pre_q,  pre_d;
    urff_flag_t  post_q, post_d;
    logic        v0_q,   v0_d;
    logic        v1_q,   v1_d;
    urff_byte_t  d0_q,   d0_d;
    urff_byte_t  d1_q,   d1_d;
    logic        push;
    logic        take;

    // Reserved flag bit is never trusted
    function automatic urff_flag_t clean(input urff_flag_t f);
        clean                   = f;
        clean[`URFF_FLAG_RSVD]  = 1'b0;                               // RL3
    endfunction

    // ============================================================
    // Sequencer and two-entry output buffer
    always_comb
    begin
        st_d   = st_q;
        op_d   = op_q;
        rd_d   = 1'b0;
        rc_d   = 1'b0;
        done_d = 1'b0;
        disc_d = disc_q;
        pre_d  = pre_q;
        post_d = post_q;
        v0_d   = v0_q;
        v1_d   = v1_q;
        d0_d   = d0_q;
        d1_d   = d1_q;
        take   = CMD_VALID && rdy_q;
        push   = rd_q;

        unique case (st_q)
            URFF_IDLE:
            begin
                if (take)
                begin
                    pre_d = clean(BUS.flag);                          // RL1
                    op_d  = CMD_OP;
                    st_d  = URFF_WAIT;
                    if (CMD_OP == URFF_OP_READ)
                    begin
                        rd_d = 1'b1;
                    end
                    else
                    begin
                        // Always completed, even after a flush
                        rc_d   = 1'b1;                                // RL10
                        disc_d = BUS.flag[`URFF_FLAG_FLUSH];          // RL8
                    end
                end
            end
            URFF_WAIT:
            begin
                // Strobe cycle first; flags show the effect one cycle later
                if (!rd_q && !rc_q)
                begin
                    post_d = clean(BUS.flag);                         // RL1
                    done_d = 1'b1;
                    st_d   = URFF_IDLE;
                end
            end
        endcase

        // Pop then shift, then push into first free entry
        if (v0_q && OUT_READY)
        begin
            v0_d = v1_q;
            d0_d = d1_q;
            v1_d = 1'b0;
        end
        if (push)
        begin
            if (!v0_d)
            begin
                v0_d = 1'b1;
                d0_d = BUS.rd_data;
            end
            else
            begin
                v1_d = 1'b1;
                d1_d = BUS.rd_data;
            end
        end

        // Stall on a full buffer so a slow reader loses no byte
        rdy_d = (st_d == URFF_IDLE) && !take && !(v0_d && v1_d);
    end

    // ============================================================
    // Registers
    always_ff @(posedge MCLK)
    begin
        if (!NRST)
        begin
            st_q   <= URFF_IDLE;
            op_q   <= URFF_OP_READ;
            rd_q   <= 1'b0;
            rc_q   <= 1'b0;
            rdy_q  <= 1'b0;
            done_q <= 1'b0;
            disc_q <= 1'b0;
            pre_q  <= 8'h00;
            post_q <= 8'h00;
            v0_q   <= 1'b0;
            v1_q   <= 1'b0;
            d0_q   <= '0;
            d1_q   <= '0;
        end
        else
        begin
            st_q   <= st_d;
            op_q   <= op_d;
            rd_q   <= rd_d;
            rc_q   <= rc_d;
            rdy_q  <= rdy_d;
            done_q <= done_d;
            disc_q <= disc_d;
            pre_q  <= pre_d;
            post_q <= post_d;
            v0_q   <= v0_d;
            v1_q   <= v1_d;
            d0_q   <= d0_d;
            d1_q   <= d1_d;
        end
    end

    // ============================================================
    // Outputs
    assign BUS.rd_strobe = rd_q;
    assign BUS.rc_strobe = rc_q;
    assign CMD_READY     = rdy_q;
    assign OUT_VALID     = v0_q;
    assign OUT_DATA      = d0_q;
    assign FLAG_PRE      = pre_q;
    assign FLAG_POST     = post_q;
    assign DONE          = done_q;
    assign DISCARD       = disc_q;

endmodule // urff_fw

// ---- urff_checker.sv ----
`timescale 1ns/10ps
module urff_checker
    import urff_pkg::*;
(
    input wire logic       MCLK,
    input wire logic       NRST,
    input wire logic       rd_strobe,
    input wire logic       rc_strobe,
    input wire urff_byte_t rd_data,
    input wire urff_flag_t flag,
    input wire logic       FEATURE_ENABLE,
    input wire logic       ISO_MODE,
    input wire logic       SOF_PULSE
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!NRST);
    // ==========
    // Flag word
    property p_rsvd;
        flag[5] == 1'h0;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
    property p_idx_code;
        flag[7:6] != 2'h2;
    endproperty
    a_idx_code: assert property (p_idx_code) else $error("bad index code");
    // Iso sets only appear at SOF
    property p_iso_defer;
        ISO_MODE && !SOF_PULSE |=> flag[7:6] <= $past(flag[7:6]);
    endproperty
    a_iso_defer: assert property (p_iso_defer) else $error("iso index rose off SOF");
    // ==========
    // Flush
    property p_flush_cause;
        $rose(flag[4]) |-> $past(SOF_PULSE) && $past(FEATURE_ENABLE) && $past(ISO_MODE);
    endproperty
    a_flush_cause: assert property (p_flush_cause) else $error("flush without SOF");
    property p_flush_idx;
        $rose(flag[4]) |-> $past(flag[7:6]) != 2'h0;
    endproperty
    a_flush_idx: assert property (p_flush_idx) else $error("flush with no set");
    property p_rc_clr;
        rc_strobe && !SOF_PULSE |=> !flag[4];
    endproperty
    a_rc_clr: assert property (p_rc_clr) else $error("flush not cleared");
    property p_rd_block;
        rd_strobe && flag[4] && !SOF_PULSE |=> $stable(rd_data) && $stable(flag);
    endproperty
    a_rd_block: assert property (p_rd_block) else $error("read acted while flushed");
    // ==========
    // Empty
    property p_empty_idle;
        flag[7:6] == 2'h0 |-> flag[3];
    endproperty
    a_empty_idle: assert property (p_empty_idle) else $error("empty low with no set");
    property p_empty_rise;
        $rose(flag[3]) |-> $past(rd_strobe) || $past(rc_strobe) || $past(SOF_PULSE);
    endproperty
    a_empty_rise: assert property (p_empty_rise) else $error("empty rose uncaused");
endmodule // urff_checker

// ---- tb_top.sv ----
`timescale 1ns/10ps
module tb_top;
    import urff_pkg::*;
    localparam int DEPTH = 4;
    logic       mclk, nrst, feature_enable, iso_mode, sof_pulse, usb_valid, usb_last, usb_ready;
    logic       flush_event, cmd_valid, cmd_ready, out_valid, out_ready, done, discard, flush, due;
    urff_byte_t usb_data, out_data, data_q[$];
    urff_op_e   cmd_op;
    urff_flag_t flag_pre, flag_post;
    int         mismatches, num_checks, seed, cycles, rdn, pend, lens[$], exp_q[$];
    urff_if i_urff_if ();
    urff_dev #(.DEPTH(DEPTH)) i_urff_dev (.MCLK(mclk), .NRST(nrst), .BUS(i_urff_if),
        .FEATURE_ENABLE(feature_enable), .ISO_MODE(iso_mode), .SOF_PULSE(sof_pulse), .USB_VALID(usb_valid),
        .USB_DATA(usb_data), .USB_LAST(usb_last), .USB_READY(usb_ready), .FLUSH_EVENT(flush_event));
    urff_fw i_urff_fw (.MCLK(mclk), .NRST(nrst), .BUS(i_urff_if), .CMD_VALID(cmd_valid), .CMD_OP(cmd_op),
        .CMD_READY(cmd_ready), .OUT_VALID(out_valid), .OUT_DATA(out_data), .OUT_READY(out_ready),
        .FLAG_PRE(flag_pre), .FLAG_POST(flag_post), .DONE(done), .DISCARD(discard));
    urff_checker i_urff_checker (.MCLK(mclk), .NRST(nrst), .rd_strobe(i_urff_if.rd_strobe),
        .rc_strobe(i_urff_if.rc_strobe), .rd_data(i_urff_if.rd_data), .flag(i_urff_if.flag),
        .FEATURE_ENABLE(feature_enable), .ISO_MODE(iso_mode), .SOF_PULSE(sof_pulse));
    // ==========
    // Helpers
    task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic step(int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    function automatic urff_flag_t exp_flag();
        int nv;
        nv = lens.size() - pend;
        return {((nv == 2) ? 2'h3 : {1'h0, nv == 1}), 1'h0, flush, (nv == 0 || rdn == lens[0]), 3'h0};
    endfunction
    task automatic drop_set();
        repeat (lens.pop_front()) void'(data_q.pop_front());
        rdn = 0;
    endtask
    // ==========
    // Stimulus and model
    task automatic send_set(int len);
        for (int i = 0; i < len; i++)
        begin
            usb_valid = 1'h1;
            usb_data = 8'($random(seed));
            usb_last = (i == len - 1);
            for (int k = 0; k < 50 && !usb_ready; k++) step(1);
            chk("usb_wait", usb_ready, 1'h1);
            data_q.push_back(usb_data);
            step(1);
        end
        usb_valid = 1'h0;
        usb_last = 1'h0;
        lens.push_back(len);
        if (iso_mode) pend++;
        step(1);
        chk("flag_set", i_urff_if.flag, exp_flag());
    endtask
    task automatic cmd(urff_op_e op);
        urff_flag_t e;
        e = exp_flag();
        // Queued before the strobe: the byte may leave the buffer before DONE
        if (op == URFF_OP_READ)
        begin
            if (!flush && lens.size() > pend && rdn < lens[0])
            begin
                exp_q.push_back(data_q[rdn]);
                rdn++;
            end
            else exp_q.push_back(-1);
        end
        cmd_valid = 1'h1;
        cmd_op = op;
        for (int k = 0; k < 50 && !cmd_ready; k++) step(1);
        chk("cmd_ready", cmd_ready, 1'h1);
        step(1);
        cmd_valid = 1'h0;
        for (int k = 0; k < 8 && !done; k++) step(1);
        chk("done", done, 1'h1);
        chk("flag_pre", flag_pre, e);
        if (op == URFF_OP_DONE)
        begin
            chk("discard", discard, flush);
            if (flush) flush = 1'h0;
            else if (lens.size() > pend)
            begin
                drop_set();
                due = iso_mode;
            end
        end
        chk("flag_post", flag_post, exp_flag());
    endtask
    task automatic sof();
        logic f;
        sof_pulse = 1'h1;
        step(1);
        sof_pulse = 1'h0;
        f = iso_mode && feature_enable && due && lens.size() > pend;
        if (f) drop_set();
        if (f) flush = 1'h1;
        if (iso_mode) pend = 0;
        if (iso_mode) due = lens.size() > 0;
        chk("flush_event", flush_event, f);
        chk("flag_sof", i_urff_if.flag, exp_flag());
    endtask
    task automatic drain_all();
        while (lens.size() > pend)
        begin
            repeat (lens[0] + 1) cmd(URFF_OP_READ);
            cmd(URFF_OP_DONE);
        end
    endtask
    task automatic rst(logic iso, logic feat);
        if (nrst)
        begin
            step(20);
            chk("left", exp_q.size(), 0);
        end
        nrst = 1'h0;
        iso_mode = iso;
        feature_enable = feat;
        step(4);
        nrst = 1'h1;
        lens = {};
        data_q = {};
        {rdn, pend, flush, due} = '0;
        step(2);
        chk("flag_rst", i_urff_if.flag, 8'h08);
    endtask
    // ==========
    // Clock, drain and watchdog
    initial
    begin
        mclk = 1'h0;
        forever #5 mclk = ~mclk;
    end
    // Stalls the reader at random so the two-entry buffer fills
    always @(posedge mclk)
    begin
        #1 out_ready = 1'($random(seed));
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            end_sim();
        end
    end
    // Negative entries stand for refused reads whose byte is junk
    always @(negedge mclk)
    begin
        if (nrst && out_valid && out_ready)
        begin
            if (exp_q.size() == 0) chk("out_extra", 8'h1, 8'h0);
            else if (exp_q[0] < 0) void'(exp_q.pop_front());
            else chk("out_data", out_data, 8'(exp_q.pop_front()));
        end
    end
    initial
    begin
        seed = 83;
        {nrst, feature_enable, iso_mode, sof_pulse, usb_valid, usb_last, cmd_valid, out_ready} = '0;
        usb_data = 8'h00;
        cmd_op = URFF_OP_READ;
        rst(1'h0, 1'h1);
        for (int r = 0; r < 3; r++)
        begin
            send_set(r == 0 ? DEPTH : 1 + {$random(seed)} % DEPTH);
            send_set(1 + {$random(seed)} % DEPTH);
            chk("usb_ready", usb_ready, 1'h0);
            sof();
            drain_all();
            cmd(URFF_OP_DONE);
        end
        send_set(DEPTH);
        drain_all();
        $display("test non_iso done");
        rst(1'h1, 1'h1);
        send_set(2);
        sof();
        drain_all();
        send_set(3);
        sof();
        cmd(URFF_OP_READ);
        sof();
        cmd(URFF_OP_READ);
        cmd(URFF_OP_DONE);
        send_set(1);
        send_set(2);
        sof();
        drain_all();
        $display("test iso_flush done");
        rst(1'h1, 1'h0);
        send_set(1);
        sof();
        sof();
        drain_all();
        $display("test iso_nofeat done");
        step(20);
        chk("left", exp_q.size(), 0);
        end_sim();
    end
endmodule // tb_top
